// ==== src/io_bus_adapter_port.sv ====
// channel processor side of the host bus adapter: external registers,
// transfer buffers, parity checkers, host request levels and wrap logic
// assumes register port and buffer/store ports on CLK; host pins are async
`timescale 1ns/1ps
`default_nettype none

module io_bus_adapter_port
    import adapter_port_pkg::*;
#(
    parameter int unsigned TIMER_TICKS = TIMER_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // external register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RDATA_PAR,
    // transfer buffer access
    input wire buf_req_s BUF_REQ,
    output logic [15:0] BUF_RDATA,
    // transfers into control store
    input wire store_wr_s STORE_WR,
    // processor interrupt levels
    output logic [7:0] PROC_INT_REQ,
    output logic PROC_INT_ANY,
    output logic [2:0] PROC_INT_LEVEL,
    // host bus pins
    input wire logic HOST_WRITE_STB,
    input wire logic [15:0] HOST_DATA,
    input wire logic HOST_IO_TAG,
    input wire logic HOST_TRANSFER_ACCEPT_TAG,
    input wire logic HOST_GET_ERROR_STATUS,
    input wire logic HOST_GET_LINE_ID,
    output logic HOST_REQUEST_LEVEL1,
    output logic HOST_REQUEST_LEVEL2,
    output logic HOST_CHANNEL_REQ,
    output logic HOST_PRIORITY_HIGH,
    output logic HOST_IO_TAG_OUT,
    output logic HALT_PULSE,
    output logic [7:0] FAULT_ISOLATION_CODE
);

    if (TIMER_TICKS < 2) begin : g_bad_timer
        $error("TIMER_TICKS must be at least 2");
    end

    function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] r);
        hit = stb && (a == r);
    endfunction

    // busy is set by anything that fills or moves a buffer via the store path
    function automatic logic sets_busy(input buf_op_e op, input logic we);
        unique case (op)
            OP_REGISTER_LOAD, OP_REGISTER_LOAD_INC: sets_busy = 1'b0;
            OP_HALFWORD_REGISTER_LOAD: sets_busy = we;
            OP_CS_LOAD_HALFWORD, OP_CS_LOAD_HALFWORD_INC: sets_busy = 1'b1;
            OP_CS_STORE_HALFWORD, OP_CS_STORE_HALFWORD_INC: sets_busy = 1'b1;
            default: sets_busy = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] top_level(input logic [7:0] req);
        top_level = 3'd7;
        for (int i = 0; i < 8; i++) begin
            if (req[i]) begin
                top_level = 3'(7 - i);
            end
        end
    endfunction

    logic [7:0] xc_q, xc_d;
    logic [7:0] bt_q, bt_d;
    logic [7:0] ts_q, ts_d;
    logic [7:0] er_q, er_d;
    logic [7:0] as_q, as_d;
    logic [7:0] hp_q, hp_d;
    logic [7:0] inj_q;
    logic [7:0] pci_q;
    logic [7:0] pci_req_q;
    logic [31:0] timer_q;
    logic timer_tick;
    logic halt_q;
    logic [7:0] fault_q;
    logic [15:0] buf_mem [2];
    logic [15:0] buf_rdata_q;
    logic [7:0] rdata_q;
    logic rpar_q;

    logic wr_xc, wr_bt, wr_ts, wr_er, wr_as, wr_hp;
    logic any_access, in_scanner, adapter_err;
    logic buf_hit, buf_busy_set, ping_set, pong_set;
    logic data_par_err, addr_par_err;
    logic test_drive, io_tag_set;

    // host pins: two-flop synchronisers, third stage for edges
    localparam int HW = 21;
    logic [HW-1:0] host_s1_q, host_s2_q;
    logic [2:0] host_s3_q;
    logic host_write_ev, host_ges_ev, host_gli_ev;
    logic host_io, host_ta;
    logic [15:0] host_data;
    logic resp_ok, resp_err;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            host_s1_q <= '0;
            host_s2_q <= '0;
            host_s3_q <= '0;
        end else begin
            host_s1_q <= {HOST_WRITE_STB, HOST_GET_ERROR_STATUS, HOST_GET_LINE_ID,
                          HOST_IO_TAG, HOST_TRANSFER_ACCEPT_TAG, HOST_DATA};
            host_s2_q <= host_s1_q;
            host_s3_q <= host_s2_q[HW-1:HW-3];
        end
    end

    assign host_write_ev = host_s2_q[HW-1] && !host_s3_q[2];
    assign host_ges_ev = host_s2_q[HW-2] && !host_s3_q[1];
    assign host_gli_ev = host_s2_q[HW-3] && !host_s3_q[0];
    assign host_io = host_s2_q[17];
    assign host_ta = host_s2_q[16];
    assign host_data = host_s2_q[15:0];

    // host programmed write: tags on, first buffer idle, data all ones
    assign resp_ok = host_write_ev && host_io && host_ta && !bt_q[BT_PING_BUSY]
                     && (host_data == HOST_GOOD_DATA);
    assign resp_err = host_write_ev && !resp_ok;

    assign wr_xc = hit(REG_WR, REG_ADDR, REG_HOST_EXCHANGE_CONTROL);
    assign wr_bt = hit(REG_WR, REG_ADDR, REG_BUS_TRANSFER_CONTROL);
    assign wr_ts = hit(REG_WR, REG_ADDR, REG_BUS_TAG_SERVICE);
    assign wr_er = hit(REG_WR, REG_ADDR, REG_ERROR_ORIGIN);
    assign wr_as = hit(REG_WR, REG_ADDR, REG_ADAPTER_SELECT_AND_WRAP);
    assign wr_hp = hit(REG_WR, REG_ADDR, REG_HOST_INTERRUPT_PRIORITY);

    assign any_access = REG_WR || REG_RD;
    assign in_scanner = (REG_ADDR >= SCANNER_FIRST) && (REG_ADDR <= SCANNER_LAST);
    // only the scanner window is checked; other numbers never fault
    assign adapter_err = any_access && in_scanner && !as_q[AS_ADAPTER_SEL];

    assign buf_hit = BUF_REQ.valid && (BUF_REQ.page == BUF_PAGE)
                     && (BUF_REQ.addr <= BUF_LAST_ADDR);
    assign buf_busy_set = buf_hit && sets_busy(BUF_REQ.op, BUF_REQ.we);
    assign ping_set = buf_busy_set && !BUF_REQ.addr[1];
    assign pong_set = buf_busy_set && BUF_REQ.addr[1];

    // odd parity; read-only store reads have no port here, so never fault
    assign data_par_err = STORE_WR.valid && !(^{STORE_WR.data, STORE_WR.data_par});
    assign addr_par_err = STORE_WR.valid && (STORE_WR.addr >= STORE_CHECK_FIRST)
                          && !(^{STORE_WR.addr, STORE_WR.addr_par});

    assign test_drive = ts_q[TS_TEST_DRIVE];
    assign io_tag_set = wr_ts && REG_WDATA[TS_IO_TAG];
    assign timer_tick = (timer_q == 32'(TIMER_TICKS - 1));

    always_ff @(posedge CLK) begin
        if (SRST) begin
            timer_q <= '0;
        end else if (timer_tick) begin
            timer_q <= '0;
        end else begin
            timer_q <= timer_q + 32'd1;
        end
    end

    // exchange control: timer bit set by hardware, only cleared by software
    always_comb begin
        xc_d = xc_q;
        if (wr_xc) begin
            xc_d = (REG_WDATA & ~(8'h01 << XC_TIMER)) | (xc_q & REG_WDATA & (8'h01 << XC_TIMER));
        end
        if (timer_tick) begin
            xc_d[XC_TIMER] = 1'b1;
        end
        if (pong_set) begin
            xc_d[XC_PONG_BUSY] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            xc_q <= REG_RESET;
        end else begin
            xc_q <= xc_d;
        end
    end

    always_comb begin
        bt_d = bt_q;
        if (wr_bt) begin
            bt_d = REG_WDATA;
        end
        if (ping_set) begin
            bt_d[BT_PING_BUSY] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            bt_q <= REG_RESET;
        end else begin
            bt_q <= bt_d;
        end
    end

    // halt is a write-only action, never stored
    always_comb begin
        ts_d = ts_q;
        if (wr_ts) begin
            ts_d = REG_WDATA & ~(8'h01 << TS_HALT);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ts_q <= REG_RESET;
            halt_q <= 1'b0;
        end else begin
            ts_q <= ts_d;
            halt_q <= wr_ts && REG_WDATA[TS_HALT];
        end
    end

    // error origin: sources win over a software write in the same cycle
    always_comb begin
        er_d = er_q;
        if (wr_er) begin
            er_d = REG_WDATA;
        end
        if (adapter_err) begin
            er_d[ER_ADAPTER] = 1'b1;
        end
        if (wr_ts && REG_WDATA[TS_BUS_CHECK]) begin
            er_d[ER_BUS_CHECK] = 1'b1;
        end
        if (data_par_err) begin
            er_d[ER_DATA_PAR] = 1'b1;
            er_d[ER_PARITY] = 1'b1;
        end
        if (addr_par_err) begin
            er_d[ER_ADDR_PAR] = 1'b1;
            er_d[ER_PARITY] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            er_q <= REG_RESET;
        end else begin
            er_q <= er_d;
        end
    end

    // channel wrap only follows the request once test drive has been seen
    always_comb begin
        as_d = as_q;
        if (wr_as) begin
            as_d[AS_ADAPTER_SEL] = REG_WDATA[AS_ADAPTER_SEL];
        end
        as_d[AS_CHANNEL_WRAP] = (as_q[AS_CHANNEL_WRAP] || test_drive)
                                && bt_q[BT_CHANNEL_REQ];
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            as_q <= REG_RESET;
        end else begin
            as_q <= as_d;
        end
    end

    always_comb begin
        hp_d = hp_q;
        if (wr_hp) begin
            hp_d[HP_LEVEL1] = REG_WDATA[HP_LEVEL1];
            hp_d[HP_LEVEL2] = REG_WDATA[HP_LEVEL2];
            hp_d[HP_PRIORITY_HIGH] = REG_WDATA[HP_PRIORITY_HIGH];
        end
        if (host_ges_ev) begin
            hp_d[HP_LEVEL1] = 1'b0;
        end
        if (host_gli_ev) begin
            hp_d[HP_LEVEL2] = 1'b0;
        end
        if (resp_err) begin
            hp_d[HP_LEVEL1] = 1'b1;
        end
        if (resp_ok) begin
            hp_d[HP_LEVEL2] = 1'b1;
        end
        hp_d[HP_LEVEL1_DIAG] = !io_tag_set && (hp_q[HP_LEVEL1_DIAG]
                               || (hp_q[HP_LEVEL1] && test_drive));
        hp_d[HP_LEVEL2_DIAG] = !io_tag_set && (hp_q[HP_LEVEL2_DIAG]
                               || (hp_q[HP_LEVEL2] && test_drive));
        hp_d[HP_PRIORITY_DIAG] = (hp_q[HP_PRIORITY_DIAG] || test_drive)
                                 && hp_q[HP_PRIORITY_HIGH];
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            hp_q <= REG_RESET;
            fault_q <= FAULT_NONE;
        end else begin
            hp_q <= hp_d;
            if (resp_err) begin
                fault_q <= FAULT_HOST_CHECK;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            inj_q <= REG_RESET;
            pci_q <= REG_RESET;
        end else begin
            if (hit(REG_WR, REG_ADDR, REG_PARITY_FAULT_INJECTOR)) begin
                inj_q <= REG_WDATA;
            end
            if (hit(REG_WR, REG_ADDR, REG_PROGRAM_INTERRUPT)) begin
                pci_q <= REG_WDATA;
            end
        end
    end

    // index 7 is level 0 (highest), index 0 is level 7
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pci_req_q <= REG_RESET;
        end else begin
            pci_req_q <= pci_q | {|er_q, xc_q[XC_REQ0] || xc_q[XC_REQ1], 6'h00};
        end
    end

    always_ff @(posedge CLK) begin
        if (buf_hit && BUF_REQ.we) begin
            buf_mem[BUF_REQ.addr[1]] <= BUF_REQ.wdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            buf_rdata_q <= '0;
        end else if (buf_hit && !BUF_REQ.we) begin
            buf_rdata_q <= buf_mem[BUF_REQ.addr[1]];
        end
    end

    // read data one cycle after the strobe; unmapped numbers read zero
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_q <= '0;
            rpar_q <= 1'b1;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                REG_HOST_EXCHANGE_CONTROL: rdata_q <= xc_q;
                REG_BUS_TRANSFER_CONTROL: rdata_q <= bt_q;
                REG_BUS_TAG_SERVICE: rdata_q <= ts_q;
                REG_ERROR_ORIGIN: rdata_q <= er_q;
                REG_ADAPTER_SELECT_AND_WRAP: rdata_q <= as_q;
                REG_HOST_INTERRUPT_PRIORITY: rdata_q <= hp_q;
                REG_PARITY_FAULT_INJECTOR: rdata_q <= inj_q;
                REG_PROGRAM_INTERRUPT: rdata_q <= pci_req_q;
                default: rdata_q <= 8'h00;
            endcase
            unique case (REG_ADDR)
                REG_HOST_EXCHANGE_CONTROL: rpar_q <= ~^xc_q;
                REG_BUS_TRANSFER_CONTROL: rpar_q <= ~^bt_q;
                REG_BUS_TAG_SERVICE: rpar_q <= ~^ts_q;
                REG_ERROR_ORIGIN: rpar_q <= ~^er_q;
                REG_ADAPTER_SELECT_AND_WRAP: rpar_q <= ~^as_q;
                REG_HOST_INTERRUPT_PRIORITY: rpar_q <= ~^hp_q;
                REG_PARITY_FAULT_INJECTOR: rpar_q <= ^inj_q;
                REG_PROGRAM_INTERRUPT: rpar_q <= ~^pci_req_q;
                default: rpar_q <= 1'b1;
            endcase
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RDATA_PAR = rpar_q;
    assign BUF_RDATA = buf_rdata_q;
    assign PROC_INT_REQ = pci_req_q;
    assign PROC_INT_ANY = |pci_req_q;
    assign PROC_INT_LEVEL = top_level(pci_req_q);
    // test drive holds the request outputs off the bus (I/O tag out still driven); requests only wrap internally
    assign HOST_REQUEST_LEVEL1 = hp_q[HP_LEVEL1] && !test_drive;
    assign HOST_REQUEST_LEVEL2 = hp_q[HP_LEVEL2] && !test_drive;
    assign HOST_CHANNEL_REQ = bt_q[BT_CHANNEL_REQ] && !test_drive;
    assign HOST_PRIORITY_HIGH = hp_q[HP_PRIORITY_HIGH] && !test_drive;
    assign HOST_IO_TAG_OUT = ts_q[TS_IO_TAG];
    assign HALT_PULSE = halt_q;
    assign FAULT_ISOLATION_CODE = fault_q;

    property p_adapter_err;
        @(posedge CLK) disable iff (SRST)
        adapter_err |=> er_q[ER_ADAPTER] ##1 PROC_INT_REQ[7];
    endproperty
    a_adapter_err: assert property (p_adapter_err) else $error("deselected access missed");

    property p_selected_quiet;
        @(posedge CLK) disable iff (SRST)
        (any_access && as_q[AS_ADAPTER_SEL] && !er_q[ER_ADAPTER] && !wr_er)
        |=> !er_q[ER_ADAPTER];
    endproperty
    a_selected_quiet: assert property (p_selected_quiet) else $error("selected access faulted");

    property p_data_par;
        @(posedge CLK) disable iff (SRST)
        data_par_err |=> er_q[ER_DATA_PAR] && er_q[ER_PARITY];
    endproperty
    a_data_par: assert property (p_data_par) else $error("data parity not latched");

    property p_addr_par;
        @(posedge CLK) disable iff (SRST)
        addr_par_err |=> er_q[ER_ADDR_PAR] && er_q[ER_PARITY] ##1 PROC_INT_REQ[7];
    endproperty
    a_addr_par: assert property (p_addr_par) else $error("address parity not latched");

    property p_inject;
        @(posedge CLK) disable iff (SRST)
        hit(REG_RD, REG_ADDR, REG_PARITY_FAULT_INJECTOR) |=> (REG_RDATA_PAR == ^REG_RDATA);
    endproperty
    a_inject: assert property (p_inject) else $error("injector parity is good");

    property p_timer;
        @(posedge CLK) disable iff (SRST)
        timer_tick |=> xc_q[XC_TIMER];
    endproperty
    a_timer: assert property (p_timer) else $error("timer bit not set");

    property p_level1_proc;
        @(posedge CLK) disable iff (SRST)
        (xc_q[XC_REQ0] || xc_q[XC_REQ1]) |=> PROC_INT_REQ[6];
    endproperty
    a_level1_proc: assert property (p_level1_proc) else $error("level 1 not raised");

    property p_busy;
        @(posedge CLK) disable iff (SRST)
        buf_busy_set |=> ($past(BUF_REQ.addr[1]) ? xc_q[XC_PONG_BUSY] : bt_q[BT_PING_BUSY]);
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag not set");

    property p_no_busy;
        @(posedge CLK) disable iff (SRST)
        (buf_hit && !bt_q[BT_PING_BUSY] && !BUF_REQ.addr[1] && !wr_bt
         && (BUF_REQ.op inside {OP_REGISTER_LOAD, OP_REGISTER_LOAD_INC}))
        |=> !bt_q[BT_PING_BUSY];
    endproperty
    a_no_busy: assert property (p_no_busy) else $error("register load set busy");

    property p_diag_hold;
        @(posedge CLK) disable iff (SRST)
        (hp_q[HP_LEVEL1] && test_drive && !io_tag_set) |=> hp_q[HP_LEVEL1_DIAG]
        ##1 (hp_q[HP_LEVEL1_DIAG] || $past(io_tag_set));
    endproperty
    a_diag_hold: assert property (p_diag_hold) else $error("level 1 wrap lost");

    property p_host_reply;
        @(posedge CLK) disable iff (SRST)
        resp_err |=> hp_q[HP_LEVEL1] && (FAULT_ISOLATION_CODE == FAULT_HOST_CHECK);
    endproperty
    a_host_reply: assert property (p_host_reply) else $error("host fault not shown");

    property p_host_clear;
        @(posedge CLK) disable iff (SRST)
        (host_gli_ev && !resp_ok && !wr_hp) |=> !hp_q[HP_LEVEL2];
    endproperty
    a_host_clear: assert property (p_host_clear) else $error("level 2 not dropped");

endmodule

`default_nettype wire

// ==== src/adapter_port_pkg.sv ====
// constants, types and register map of the channel processor bus adapter port
// assumes one 250 MHz clock; bit n of a register sits at index 7-n
//
// Summary of operation
// - scanner access while deselected raises level 0
// - selected, unimplemented or outside register: no level 0
// - bad store data parity sets error bits 1,2
// - bad store address parity at 0x1000 and above sets error bits 2,4
// - injector register reads back with wrong parity
// - read-only store reads never raise level 0
// - exchange bits writable; bit 2 is 100 ms timer
// - exchange bits 0 or 1 raise level 1
// - transfer control bits read back as written
// - tag service writable except halt bit 4
// - tag service bit 1 sets bus check, level 0
// - buffers at page 2, addresses 0 to 3
// - buffer writes other than register loads set their busy flags
// - store ops and halfword write set busy
// - register loads and halfword reads leave busy
// - request with test drive latches diagnostic wrap
// - setting I/O tag clears interrupt wrap
// - channel wrap follows request once test drive
// - priority diagnostic latches, survives test drive reset
// - host write checked; level 1 fault else level 2
// - error status drops level 1, line id level 2
// - error register latches each level 0 source
// - level 0 highest, one request bit per level
package adapter_port_pkg;

    localparam logic [7:0] REG_HOST_EXCHANGE_CONTROL = 8'h00;
    localparam logic [7:0] REG_BUS_TRANSFER_CONTROL = 8'h01;
    localparam logic [7:0] REG_BUS_TAG_SERVICE = 8'h02;
    localparam logic [7:0] REG_ERROR_ORIGIN = 8'h03;
    localparam logic [7:0] REG_ADAPTER_SELECT_AND_WRAP = 8'h04;
    localparam logic [7:0] REG_HOST_INTERRUPT_PRIORITY = 8'h05;
    localparam logic [7:0] REG_PARITY_FAULT_INJECTOR = 8'h08;
    localparam logic [7:0] REG_PROGRAM_INTERRUPT = 8'h25;
    localparam logic [7:0] SCANNER_FIRST = 8'h10;
    localparam logic [7:0] SCANNER_LAST = 8'h23;
    localparam logic [7:0] REG_RESET = 8'h00;

    // field positions (index = 7 - documented bit number)
    localparam int XC_REQ0 = 7;
    localparam int XC_REQ1 = 6;
    localparam int XC_TIMER = 5;
    localparam int XC_PONG_BUSY = 1;
    localparam int BT_CHANNEL_REQ = 5;
    localparam int BT_PING_BUSY = 1;
    localparam int TS_BUS_CHECK = 6;
    localparam int TS_IO_TAG = 4;
    localparam int TS_HALT = 3;
    localparam int TS_TEST_DRIVE = 1;
    localparam int AS_ADAPTER_SEL = 1;
    localparam int AS_CHANNEL_WRAP = 0;
    localparam int HP_LEVEL1 = 6;
    localparam int HP_LEVEL2 = 5;
    localparam int HP_LEVEL1_DIAG = 4;
    localparam int HP_LEVEL2_DIAG = 3;
    localparam int HP_PRIORITY_HIGH = 2;
    localparam int HP_PRIORITY_DIAG = 1;
    localparam int ER_ADAPTER = 7;
    localparam int ER_DATA_PAR = 6;
    localparam int ER_PARITY = 5;
    localparam int ER_BUS_CHECK = 4;
    localparam int ER_ADDR_PAR = 3;

    localparam logic [2:0] BUF_PAGE = 3'h2;
    localparam logic [7:0] BUF_LAST_ADDR = 8'h03;
    localparam logic [15:0] STORE_CHECK_FIRST = 16'h1000;
    localparam logic [15:0] HOST_GOOD_DATA = 16'hFFFF;
    localparam logic [7:0] FAULT_HOST_CHECK = 8'h03;
    localparam logic [7:0] FAULT_NONE = 8'h00;

    localparam int TIMER_MS = 100;
    localparam int CLK_KHZ = 250000;
    localparam int TIMER_CYCLES = TIMER_MS * CLK_KHZ;

    typedef enum logic [2:0] {
        OP_REGISTER_LOAD,
        OP_REGISTER_LOAD_INC,
        OP_HALFWORD_REGISTER_LOAD,
        OP_CS_LOAD_HALFWORD,
        OP_CS_LOAD_HALFWORD_INC,
        OP_CS_STORE_HALFWORD,
        OP_CS_STORE_HALFWORD_INC
    } buf_op_e;

    typedef struct packed {
        logic valid;
        logic we;
        buf_op_e op;
        logic [2:0] page;
        logic [7:0] addr;
        logic [15:0] wdata;
    } buf_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic addr_par;
        logic [15:0] data;
        logic data_par;
    } store_wr_s;

endpackage

// ==== tb/host_unit_model.sv ====
// model of the central control unit driving the host bus pins
// assumes the adapter samples these pins through its own synchronisers
`timescale 1ns/1ps
`default_nettype none

module host_unit_model (
    // clock
    input wire logic CLK,
    // host pins
    output logic STB,
    output logic [15:0] DATA,
    output logic IO_TAG,
    output logic TA_TAG,
    output logic ERR_CMD,
    output logic LINE_CMD
);
    initial begin
        {STB, DATA, IO_TAG, TA_TAG, ERR_CMD, LINE_CMD} = '0;
    end

    // tags and data settle 3 clocks before the strobe
    task automatic write_word(input logic [15:0] d, input logic io, input logic ta);
        @(posedge CLK);
        DATA <= d;
        IO_TAG <= io;
        TA_TAG <= ta;
        repeat (3) @(posedge CLK);
        STB <= 1'b1;
        repeat (3) @(posedge CLK);
        STB <= 1'b0;
        @(posedge CLK);
        // released bus shows no stale value
        DATA <= ~d;
        IO_TAG <= 1'b0;
        TA_TAG <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask

    // err=1 get-error-status, err=0 get-line-identifier
    task automatic command(input logic err);
        @(posedge CLK);
        ERR_CMD <= err;
        LINE_CMD <= !err;
        repeat (3) @(posedge CLK);
        {ERR_CMD, LINE_CMD} <= 2'b00;
        repeat (3) @(posedge CLK);
    endtask
endmodule

`default_nettype wire

// ==== tb/tb_io_bus_adapter_port.sv ====
// self-checking bench for the bus adapter port
// assumes a short timer so the timer bit is masked in exchange reads
`timescale 1ns/1ps
`default_nettype none

module tb_io_bus_adapter_port;
    import adapter_port_pkg::*;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_par;
    logic [7:0] reg_addr = '0, reg_wdata = '0, rdata, rd_val, fault_isolation_code, int_req;
    logic [15:0] buf_rdata, host_data;
    buf_req_s buf_req = '0;
    store_wr_s store_wr = '0;
    logic stb, io_tag, ta_tag, err_cmd, line_cmd, lvl1, lvl2;
    logic [3:0] watch;
    int failures = 0, compares = 0;
    assign watch = {lvl1, lvl2, int_req[7], int_req[6]};
    always #2 clk = ~clk;

    io_bus_adapter_port #(.TIMER_TICKS(16)) io_bus_adapter_port_i (
        .CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .REG_RDATA_PAR(rd_par),
        .BUF_REQ(buf_req), .BUF_RDATA(buf_rdata), .STORE_WR(store_wr),
        .PROC_INT_REQ(int_req), .PROC_INT_ANY(), .PROC_INT_LEVEL(),
        .HOST_WRITE_STB(stb), .HOST_DATA(host_data), .HOST_IO_TAG(io_tag),
        .HOST_TRANSFER_ACCEPT_TAG(ta_tag), .HOST_GET_ERROR_STATUS(err_cmd),
        .HOST_GET_LINE_ID(line_cmd), .HOST_REQUEST_LEVEL1(lvl1),
        .HOST_REQUEST_LEVEL2(lvl2), .HOST_CHANNEL_REQ(), .HOST_PRIORITY_HIGH(),
        .HOST_IO_TAG_OUT(), .HALT_PULSE(), .FAULT_ISOLATION_CODE(fault_isolation_code));

    host_unit_model host_unit_model_i (
        .CLK(clk), .STB(stb), .DATA(host_data), .IO_TAG(io_tag), .TA_TAG(ta_tag),
        .ERR_CMD(err_cmd), .LINE_CMD(line_cmd));

    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = rdata;
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        rd(a);
        cmp($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd_val & m});
    endtask

    // bounded wait; running out ends the run
    task automatic wt(input int i, input logic e, input string n);
        repeat (3) @(posedge clk);
        for (int k = 0; k < 12 && watch[i] !== e; k++) @(posedge clk);
        cmp(n, {15'h0, e}, {15'h0, watch[i]});
        if (watch[i] !== e) wrap_up();
    endtask

    task automatic bufx(input logic we, input buf_op_e op, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge clk);
        buf_req <= '{1'b1, we, op, BUF_PAGE, a, d};
        @(posedge clk);
        buf_req.valid <= 1'b0;
    endtask

    task automatic st(input logic [15:0] a, input logic ap, input logic [15:0] d,
        input logic dp);
        @(posedge clk);
        store_wr <= '{1'b1, a, ap, d, dp};
        @(posedge clk);
        store_wr.valid <= 1'b0;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++)
            chk(i < 6 ? 8'(i) : 8'h30, 8'h00, 8'hDF);
        $display("test reset done");
        wr(8'h01, 8'hA5);
        chk(8'h01, 8'hA5, 8'hFF);
        wr(8'h01, 8'h5A);
        chk(8'h01, 8'h5A, 8'hFF);
        wr(8'h01, 8'h00);
        wr(REG_HOST_EXCHANGE_CONTROL, 8'h5A);
        chk(REG_HOST_EXCHANGE_CONTROL, 8'h5A, 8'hDF);
        wt(0, 1'b1, "level1");
        wr(REG_HOST_EXCHANGE_CONTROL, 8'h00);
        wt(0, 1'b0, "level1");
        $display("test registers done");
        wr(REG_BUS_TAG_SERVICE, 8'h40);
        wt(1, 1'b1, "level0");
        chk(REG_ERROR_ORIGIN, 8'h10, 8'hFF);
        wr(REG_BUS_TAG_SERVICE, 8'h00);
        wr(REG_ERROR_ORIGIN, 8'h00);
        wr(REG_ADAPTER_SELECT_AND_WRAP, 8'h02);
        rd(8'h17);
        rd(8'h29);
        wt(1, 1'b0, "level0");
        wr(REG_ADAPTER_SELECT_AND_WRAP, 8'h00);
        rd(8'h20);
        wt(1, 1'b1, "level0");
        chk(REG_ERROR_ORIGIN, 8'h80, 8'hFF);
        wr(REG_ERROR_ORIGIN, 8'h00);
        st(STORE_CHECK_FIRST, ~^STORE_CHECK_FIRST, 16'h00FF, 1'b0);
        chk(REG_ERROR_ORIGIN, 8'h60, 8'hFF);
        wt(1, 1'b1, "level0");
        wr(REG_ERROR_ORIGIN, 8'h00);
        st(16'hFFFF, 1'b0, 16'h0001, 1'b0);
        chk(REG_ERROR_ORIGIN, 8'h28, 8'hFF);
        wr(REG_ERROR_ORIGIN, 8'h00);
        wt(1, 1'b0, "level0");
        rd(REG_PARITY_FAULT_INJECTOR);
        cmp("injector parity", {15'h0, ^rd_val}, {15'h0, rd_par});
        $display("test level0 done");
        bufx(1'b1, OP_REGISTER_LOAD, 8'h00, 16'h1234);
        chk(REG_BUS_TRANSFER_CONTROL, 8'h00, 8'hFF);
        bufx(1'b1, OP_CS_STORE_HALFWORD, 8'h01, 16'hA5C3);
        chk(REG_BUS_TRANSFER_CONTROL, 8'h02, 8'hFF);
        bufx(1'b0, OP_HALFWORD_REGISTER_LOAD, 8'h00, 16'h0000);
        #1 cmp("buffer", 16'hA5C3, buf_rdata);
        chk(REG_BUS_TRANSFER_CONTROL, 8'h02, 8'hFF);
        wr(REG_BUS_TRANSFER_CONTROL, 8'h00);
        bufx(1'b0, OP_HALFWORD_REGISTER_LOAD, 8'h02, 16'h0000);
        chk(REG_HOST_EXCHANGE_CONTROL, 8'h00, 8'hDF);
        for (int op = 2; op < 7; op++) begin
            bufx(1'b1, buf_op_e'(op), 8'h02, 16'h0F0F);
            chk(REG_HOST_EXCHANGE_CONTROL, 8'h02, 8'hDF);
            wr(REG_HOST_EXCHANGE_CONTROL, 8'h00);
        end
        $display("test buffers done");
        host_unit_model_i.write_word(HOST_GOOD_DATA, 1'b1, 1'b1);
        wt(2, 1'b1, "host level2");
        host_unit_model_i.command(1'b0);
        wt(2, 1'b0, "host level2");
        host_unit_model_i.write_word(16'h7FFF, 1'b1, 1'b1);
        wt(3, 1'b1, "host level1");
        cmp("fault code", {8'h00, FAULT_HOST_CHECK}, {8'h00, fault_isolation_code});
        host_unit_model_i.command(1'b1);
        wt(3, 1'b0, "host level1");
        wr(8'h05, 8'h40);
        wr(8'h02, 8'h02);
        wr(8'h02, 8'h00);
        chk(8'h05, 8'h50, 8'hFF);
        wr(8'h02, 8'h18);
        chk(8'h02, 8'h10, 8'hFF);
        chk(8'h05, 8'h40, 8'hFF);
        wr(8'h01, 8'h20);
        chk(8'h04, 8'h00, 8'hFF);
        wr(8'h02, 8'h02);
        chk(8'h04, 8'h01, 8'hFF);
        wr(8'h05, 8'h04);
        wr(8'h02, 8'h00);
        chk(8'h05, 8'h16, 8'hFF);
        chk(8'h01, 8'h20, 8'hFF);
        $display("test host done");
        wrap_up();
    end
endmodule

`default_nettype wire
